// >>> src/tcnt_timer.sv
// Purpose: 8-bit timer/counter with prescaler, halt and overflow flag
// Assumes: Register accesses arrive as single-cycle strobes on the system clock
// Notes: Count pin must hold each level longer than one instruction cycle
`timescale 1ns/1ps
module tcnt_timer
   import tcnt_pkg::*;
#(
   parameter int CNT_W = TCNT_WIDTH,
   parameter int PSC_W = TCNT_PSC_WIDTH
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic count_wr,
   input wire logic [7:0] count_wdata,
   input wire logic ctl_wr,
   input wire tcnt_ctl_t ctl_wdata,
   input wire logic flag_wr,
   input wire logic flag_wdata,
   input wire logic ie_wr,
   input wire logic ie_wdata,
   input wire logic halt_wr,
   input wire logic halt_wdata,
   input wire logic ext_count_pin,
   output logic [7:0] timer_count_value,
   output logic overflow_flag,
   output logic overflow_irq_enable,
   output logic count_halt,
   output tcnt_ctl_t ctl_q,
   output logic counter_write_strobe,
   output logic timer_irq
);
   // ============================================================
   // Parameter checks
   // ============================================================
   // Register widths are fixed by the port list; other sizes are refused
   if (CNT_W != 8) begin : g_bad_cnt
      $error("counter width must be 8");
   end
   if (PSC_W != 8) begin : g_bad_psc
      $error("prescaler width must be 8");
   end

   // ============================================================
   // Instruction cycle enable
   // ============================================================
   logic phase_r;
   logic instr_en;
   assign instr_en = phase_r;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= ~phase_r;
      end
   end

   // ============================================================
   // Pin synchroniser and edge detect
   // ============================================================
   logic pin_sync;
   logic pin_prev_r;
   logic pin_rise;
   logic pin_fall;
   logic pin_edge;
   tcnt_sync u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .sample(instr_en),
      .din(ext_count_pin),
      .dout(pin_sync)
   );
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pin_prev_r <= 1'b0;
      end else if (instr_en) begin
         pin_prev_r <= pin_sync;
      end
   end
   // Edges seen once per instruction cycle; relies on slow pin levels
   assign pin_rise = instr_en & pin_sync & ~pin_prev_r;
   assign pin_fall = instr_en & ~pin_sync & pin_prev_r;
   assign pin_edge = ctl_q.edge_fall ? pin_fall : pin_rise;

   a_phase_flip: assert property (@(posedge clock) disable iff (!rst_b)
      1'b1 |=> phase_r != $past(phase_r))
      else $error("instruction phase stuck");
   a_sync_hold: assert property (@(posedge clock) disable iff (!rst_b)
      !instr_en |=> $stable(pin_sync))
      else $error("sync moved off enable");
   a_prev_follows: assert property (@(posedge clock) disable iff (!rst_b)
      instr_en |=> pin_prev_r == $past(pin_sync))
      else $error("edge history lost");
   a_rise_gated: assert property (@(posedge clock) disable iff (!rst_b)
      pin_rise |-> instr_en)
      else $error("edge off instruction rate");
   a_edge_rise_sel: assert property (@(posedge clock) disable iff (!rst_b)
      !ctl_q.edge_fall && pin_fall |-> !pin_edge)
      else $error("falling edge used in rise mode");
   a_edge_fall_sel: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_q.edge_fall && pin_fall |-> pin_edge)
      else $error("falling edge missed");

   // ============================================================
   // Prescaler
   // ============================================================
   logic src_pulse;
   logic psc_clear;
   logic [7:0] psc_r;
   logic [7:0] psc_nxt;
   logic [7:0] psc_mask;
   logic psc_done;
   logic count_tick;
   assign src_pulse = ctl_q.src_pin ? pin_edge : instr_en;
   assign psc_clear = ctl_wr | count_wr;
   // Mask of prescaler bits that must all be ones before a tick
   assign psc_mask = ctl_q.psc_sel[TCNT_PSC_TOP_BIT] ? 8'hFF
                   : 8'(({1'b0, 8'h01} << ctl_q.psc_sel[2:0]) - 9'h001);
   assign psc_done = (psc_r & psc_mask) == psc_mask;
   assign count_tick = src_pulse & psc_done & ~psc_clear;
   assign psc_nxt = psc_clear ? 8'h00 : (src_pulse ? (psc_done ? 8'h00 : psc_r + 8'h01) : psc_r);
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         psc_r <= 8'h00;
      end else begin
         psc_r <= psc_nxt;
      end
   end

   a_pin_src_gate: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_q.src_pin && !pin_edge |-> !count_tick)
      else $error("pin mode tick without edge");
   a_instr_src_gate: assert property (@(posedge clock) disable iff (!rst_b)
      !ctl_q.src_pin && !instr_en |-> !count_tick)
      else $error("timer mode tick off cycle");
   a_tick_instr: assert property (@(posedge clock) disable iff (!rst_b)
      count_tick && !ctl_q.src_pin |-> instr_en)
      else $error("tick not on instruction cycle");
   a_pin_tick_edge: assert property (@(posedge clock) disable iff (!rst_b)
      count_tick && ctl_q.src_pin |-> pin_edge)
      else $error("pin tick without edge");
   a_psc_wr_clear: assert property (@(posedge clock) disable iff (!rst_b)
      count_wr |=> psc_r == 8'h00)
      else $error("count write kept prescaler");
   a_clear_no_tick: assert property (@(posedge clock) disable iff (!rst_b)
      psc_clear |-> !count_tick)
      else $error("tick during prescaler clear");
   a_psc_idle: assert property (@(posedge clock) disable iff (!rst_b)
      !src_pulse && !psc_clear |=> $stable(psc_r))
      else $error("prescaler moved without source");
   a_psc_step: assert property (@(posedge clock) disable iff (!rst_b)
      src_pulse && !psc_done && !psc_clear |=> psc_r == $past(psc_r) + 8'h01)
      else $error("prescaler step wrong");
   a_psc_reload: assert property (@(posedge clock) disable iff (!rst_b)
      src_pulse && psc_done && !psc_clear |=> psc_r == 8'h00)
      else $error("prescaler not restarted");
   a_div256: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_r.psc_sel[3] && count_tick |-> psc_r == 8'hFF)
      else $error("div256 early tick");
   a_div_two: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_r.psc_sel == 4'h1 && count_tick |-> psc_r[0])
      else $error("div2 early tick");

   // ============================================================
   // Counter and flag
   // ============================================================
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   logic advance;
   logic rollover;
   logic flag_r;
   logic flag_nxt;
   logic ie_r;
   logic halt_r;
   tcnt_ctl_t ctl_r;
   logic wstb_r;
   logic irq_r;
   assign advance = count_tick & ~halt_r & ~count_wr;
   assign rollover = advance & (count_r == TCNT_COUNT_MAX);
   assign count_nxt = count_wr ? count_wdata : (advance ? count_r + 8'h01 : count_r);
   // Set beats a simultaneous software clear
   assign flag_nxt = rollover | (flag_wr ? flag_wdata & flag_r : flag_r);
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_r <= TCNT_COUNT_RESET;
         flag_r <= 1'b0;
         ie_r <= 1'b0;
         halt_r <= 1'b0;
         ctl_r <= '0;
         wstb_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         flag_r <= flag_nxt;
         ie_r <= ie_wr ? ie_wdata : ie_r;
         halt_r <= halt_wr ? halt_wdata : halt_r;
         ctl_r <= ctl_wr ? ctl_wdata : ctl_r;
         wstb_r <= count_wr;
         irq_r <= flag_nxt & (ie_wr ? ie_wdata : ie_r);
      end
   end
   assign ctl_q = ctl_r;
   assign timer_count_value = count_r;
   assign overflow_flag = flag_r;
   assign overflow_irq_enable = ie_r;
   assign count_halt = halt_r;
   assign counter_write_strobe = wstb_r;
   assign timer_irq = irq_r;

   // ============================================================
   // Checks
   // ============================================================
   sequence s_roll;
      advance && count_r == 8'hFF;
   endsequence
   a_roll_sets_flag: assert property (@(posedge clock) disable iff (!rst_b)
      s_roll |=> overflow_flag && timer_count_value == 8'h00) else $error("rollover lost");
   a_halt_holds: assert property (@(posedge clock) disable iff (!rst_b)
      halt_r && !count_wr |=> $stable(count_r)) else $error("halted counter moved");
   a_write_loads: assert property (@(posedge clock) disable iff (!rst_b)
      count_wr |=> count_r == $past(count_wdata) && counter_write_strobe) else $error("write not taken");
   a_write_clears_psc: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_wr |=> psc_r == 8'h00) else $error("prescaler not cleared");
   a_step_one: assert property (@(posedge clock) disable iff (!rst_b)
      advance |=> count_r == $past(count_r) + 8'h01) else $error("step not one");
   a_irq_gated: assert property (@(posedge clock) disable iff (!rst_b)
      timer_irq |-> overflow_flag && overflow_irq_enable) else $error("irq without enable");
   a_div_one: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_r.psc_sel == 4'h0 && !ctl_r.src_pin && instr_en && !psc_clear |-> count_tick) else $error("div1 miss");
   a_tick_needs_src: assert property (@(posedge clock) disable iff (!rst_b)
      count_tick |-> src_pulse) else $error("tick without source");
   a_instr_rate: assert property (@(posedge clock) disable iff (!rst_b)
      instr_en |=> !instr_en ##1 instr_en) else $error("instr cycle wrong");
   a_flag_clear: assert property (@(posedge clock) disable iff (!rst_b)
      flag_wr && !flag_wdata && !rollover |=> !overflow_flag) else $error("flag not cleared");

   // Back-to-back writes hold the strobe, so only a lone write is checked
   sequence s_single_write;
      count_wr ##1 !count_wr;
   endsequence
   sequence s_strobe_pulse;
      counter_write_strobe ##1 !counter_write_strobe;
   endsequence
   a_strobe_pulse: assert property (@(posedge clock) disable iff (!rst_b)
      s_single_write |-> s_strobe_pulse)
      else $error("strobe not one cycle");
   a_no_write_no_strb: assert property (@(posedge clock) disable iff (!rst_b)
      !count_wr |=> !counter_write_strobe)
      else $error("strobe without write");
   a_halt_no_roll: assert property (@(posedge clock) disable iff (!rst_b)
      halt_r |-> !rollover)
      else $error("rollover while halted");
   a_write_beats_tick: assert property (@(posedge clock) disable iff (!rst_b)
      count_wr |-> !advance)
      else $error("tick beat write");
   a_count_idle: assert property (@(posedge clock) disable iff (!rst_b)
      !count_wr && !advance |=> $stable(count_r))
      else $error("counter moved without tick");
   a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_b)
      overflow_flag && !flag_wr |=> overflow_flag)
      else $error("flag dropped by itself");
   a_flag_hw_set: assert property (@(posedge clock) disable iff (!rst_b)
      !overflow_flag && !rollover |=> !overflow_flag)
      else $error("flag set without rollover");
   a_set_wins: assert property (@(posedge clock) disable iff (!rst_b)
      flag_wr && rollover |=> overflow_flag)
      else $error("clear beat rollover");
   a_irq_follows: assert property (@(posedge clock) disable iff (!rst_b)
      overflow_flag && overflow_irq_enable |-> timer_irq)
      else $error("irq missing");
   a_irq_off: assert property (@(posedge clock) disable iff (!rst_b)
      !overflow_irq_enable |-> !timer_irq)
      else $error("irq while disabled");
   a_ie_loads: assert property (@(posedge clock) disable iff (!rst_b)
      ie_wr |=> overflow_irq_enable == $past(ie_wdata))
      else $error("enable write lost");
   a_halt_loads: assert property (@(posedge clock) disable iff (!rst_b)
      halt_wr |=> count_halt == $past(halt_wdata))
      else $error("halt write lost");
   a_ctl_loads: assert property (@(posedge clock) disable iff (!rst_b)
      ctl_wr |=> ctl_q == $past(ctl_wdata))
      else $error("control write lost");
endmodule : tcnt_timer

// >>> src/tcnt_pkg.sv
// Purpose: Shared constants and carriers for the prescaled 8-bit timer/counter
// Assumes: One instruction cycle is two system clocks
// Notes: Register fields are reached through a plain write/read port
package tcnt_pkg;
   localparam int TCNT_WIDTH = 8;
   localparam int TCNT_PSC_WIDTH = 8;
   localparam logic [7:0] TCNT_COUNT_RESET = 8'h00;
   localparam logic [7:0] TCNT_COUNT_MAX = 8'hFF;
   localparam logic [3:0] TCNT_PSC_SEL_RESET = 4'h0;
   localparam int TCNT_PSC_TOP_BIT = 3;
   localparam int TCNT_CTL_EDG_BIT = 5;
   localparam int TCNT_CTL_CKS_BIT = 4;
   localparam int TCNT_ROLL_TICKS = 256;
   localparam int TCNT_SYS_PER_INSTR = 2;
   // Control register write carrier
   typedef struct packed {
      logic edge_fall;
      logic src_pin;
      logic [3:0] psc_sel;
   } tcnt_ctl_t;
endpackage : tcnt_pkg

// >>> src/tcnt_sync.sv
// Purpose: Two-stage synchroniser for the count pin
// Assumes: Sampled only on instruction-cycle enables
// Notes: First stage is read by second stage only
`timescale 1ns/1ps
module tcnt_sync (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic sample,
   input wire logic din,
   output logic dout
);
   logic meta_r;
   logic sync_r;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else if (sample) begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end
   assign dout = sync_r;
endmodule : tcnt_sync

// >>> verification/tcnt_pulse_src.sv
// Purpose: External pulse source driving the count pin
// Assumes: Bench calls burst from its falling-edge driver
// Notes: Pin rests at its last level between bursts
`timescale 1ns/1ps
module tcnt_pulse_src (
   input wire logic clock,
   output logic ext_count_pin
);
   initial ext_count_pin = 1'b0;
   // ==========================================
   // Burst of level changes
   task automatic burst(input int n);
      int h;
      for (int i = 0; i < n; i++) begin
         h = 4 + $urandom_range(5);
         repeat (h) @(negedge clock);
         ext_count_pin = ~ext_count_pin;
      end
      // Room for the synchroniser to catch up
      repeat (12) @(negedge clock);
   endtask : burst
endmodule : tcnt_pulse_src

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the prescaled timer/counter
// Assumes: Inputs change on falling edges only
// Notes: Driver queues expected status, monitor compares
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t status %h expected %h", $time, g, e); end end
module testbench
   import tcnt_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] wr = 5'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] cnt;
   logic [7:0] r;
   logic flag, strb, irq;
   logic ie, hlt;
   tcnt_ctl_t ctlq;
   wire ext_count_pin;
   wire [10:0] stat = {strb, irq, flag, cnt};
   int miscompares = 0;
   int check_count = 0;
   int k, div;
   logic [10:0] q[$];
   event chk_ev;
   tcnt_timer uut (.clock(clock), .rst_b(rst_b), .count_wr(wr[4]), .count_wdata(wd), .ctl_wr(wr[3]),
      .ctl_wdata(tcnt_ctl_t'(wd[5:0])), .flag_wr(wr[2]), .flag_wdata(wd[0]), .ie_wr(wr[1]),
      .ie_wdata(wd[0]), .halt_wr(wr[0]), .halt_wdata(wd[0]), .ext_count_pin(ext_count_pin),
      .timer_count_value(cnt), .overflow_flag(flag), .overflow_irq_enable(ie), .count_halt(hlt),
      .ctl_q(ctlq), .counter_write_strobe(strb), .timer_irq(irq));
   tcnt_pulse_src src (.clock(clock), .ext_count_pin(ext_count_pin));
   initial forever #10 clock = ~clock;
   // ==========================================
   // Helpers
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // Gap cycle first so no strobe is set twice in one step
   task automatic put(input logic [4:0] s, input logic [7:0] d);
      @(negedge clock);
      wr = s;
      wd = d;
      @(negedge clock);
      wr = 5'h00;
   endtask : put
   task automatic note(input logic [10:0] e);
      q.push_back(e);
      ->chk_ev;
   endtask : note
   task automatic until_cnt(input logic [7:0] v, input int lim);
      int n;
      n = 0;
      while (cnt !== v) begin
         @(negedge clock);
         n++;
         if (n > lim) begin miscompares++; test_done(); end
      end
   endtask : until_cnt
   initial begin : mon
      logic [10:0] e;
      forever begin
         @(chk_ev);
         e = q.pop_front();
         `CHK(stat, e)
      end
   end
   initial begin : tmo
      repeat (50000) @(negedge clock);
      miscompares++;
      test_done();
   end
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(3760));
      repeat (16) @(negedge clock);
      rst_b = 1'b1;
      @(negedge clock);
      note(11'h000);
      r = 8'($urandom);
      put(5'h01, 8'h01);
      `CHK(hlt, 1'b1)
      put(5'h10, r);
      note({3'h4, r});
      repeat (20) @(negedge clock);
      note({3'h0, r});
      put(5'h01, 8'h00);
      // Codes 8 and 15 both fall in the divide-by-256 group
      for (int c = 0; c < 10; c++) begin
         k = (c == 9) ? 15 : c;
         div = (k > 7) ? 256 : (1 << k);
         put(5'h08, {4'h0, 4'(k)});
         `CHK(ctlq.psc_sel, 4'(k))
         put(5'h10, 8'h00);
         until_cnt(8'h01, 2 * div + 8);
         repeat (2 * div - 1) @(negedge clock);
         note({3'h0, 8'h01});
         @(negedge clock);
         note({3'h0, 8'h02});
      end
      put(5'h08, 8'h00);
      put(5'h02, 8'h01);
      `CHK(ie, 1'b1)
      put(5'h10, 8'hFD);
      until_cnt(8'h00, 20);
      note({3'h3, 8'h00});
      @(negedge clock);
      note({3'h3, 8'h00});
      put(5'h04, 8'h00);
      put(5'h02, 8'h00);
      repeat (506) @(negedge clock);
      note({3'h0, 8'hFF});
      @(negedge clock);
      note({3'h1, 8'h00});
      put(5'h04, 8'h00);
      // Odd burst length: first edge kind occurs three times
      for (int e = 0; e < 2; e++) begin
         put(5'h01, 8'h01);
         put(5'h08, {2'h0, 1'(e), 5'h10});
         `CHK(ctlq.edge_fall, 1'(e))
         put(5'h10, 8'h00);
         put(5'h01, 8'h00);
         src.burst(5);
         note({3'h0, 8'h03});
      end
      test_done();
   end
endmodule : testbench
